// ==== rtl/sig_route_pkg.sv ====
// Package: constants and carriers for the signal routing and link watch block
package sig_route_pkg;

   // Word and connector space
   localparam int DATA_W      = 16;
   localparam int CONN_W      = 9;
   localparam int NUM_CONN    = 512;
   localparam int NUM_IDX     = 4;
   localparam int NUM_TX      = 16;
   localparam int NUM_RX      = 16;
   localparam int NUM_ALARM_W = 7;
   localparam int ALARM_BITS  = 11;

   // Fixed connector numbers
   localparam logic [CONN_W-1:0] CONN_ZERO     = 9'h000;
   localparam logic [CONN_W-1:0] CONN_FULL     = 9'h001;
   localparam logic [CONN_W-1:0] CONN_DEFAULT  = 9'h002;
   localparam logic [CONN_W-1:0] CONN_MAIN_SP  = 9'h003;
   localparam logic [CONN_W-1:0] CONN_AIN1     = 9'h005;
   localparam logic [CONN_W-1:0] CONN_AIN2     = 9'h006;
   localparam logic [CONN_W-1:0] CONN_RX_FIRST = 9'h014;
   localparam logic [CONN_W-1:0] CONN_RX_LAST  = 9'h023;
   localparam logic [CONN_W-1:0] CONN_RAMP_OUT = 9'h0BE;
   localparam logic [CONN_W-1:0] CONN_RAMP_SUM = 9'h0D5;

   // Signal levels
   localparam logic [DATA_W-1:0] LVL_ZERO     = 16'h0000;
   localparam logic [DATA_W-1:0] LVL_FULL     = 16'h4000;
   localparam logic [DATA_W-1:0] LVL_NEG_FULL = 16'hC000;

   // Process data control settings
   localparam logic [3:0] PDC_ALARM = 4'h4;
   localparam logic [3:0] PDC_FAULT = 4'h5;

   // Timing
   localparam int  CLK_HZ           = 50_000_000;
   localparam real CYCLE_MS         = 3.333;
   // Cast rounds to nearest; a floor could land one clock short on the real product
   localparam int  CYCLE_CLKS       = int'(CYCLE_MS * CLK_HZ / 1000.0);
   localparam int  FAIL_TIME_W      = 16;
   localparam int  MS_CLKS          = CLK_HZ / 1000;
   // Watch runs on a half-millisecond tick, limit is 3 ticks per set ms
   localparam int  HALF_MS_CLKS     = MS_CLKS / 2;
   localparam int  FAIL_MULT        = 3;

   // Selectors of one index set
   typedef struct packed {
      logic [CONN_W-1:0] sel;
   } sel_t;

   // Group alarm words
   typedef struct packed {
      logic [NUM_ALARM_W-1:0][DATA_W-1:0] words;
   } alarm_words_t;

   // Link monitor status
   typedef struct packed {
      logic alarm;
      logic fault;
   } link_stat_t;

endpackage

// ==== rtl/link_watch.sv ====
// Telegram failure watch for one serial interface
`timescale 1ns/10ps
module link_watch
   import sig_route_pkg::*;
#(
   parameter int HALF_MS = HALF_MS_CLKS   // Clocks per half millisecond
) (
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   reset,
   // Link activity and settings
   input  wire logic                   pd_received,
   input  wire logic [FAIL_TIME_W-1:0] failure_time,
   // Failure level
   output logic                        failed
);

   // Whole state in one struct
   typedef struct packed {
      logic [31:0] pre;
      logic [31:0] ticks;
      logic        failed;
   } lw_state_t;

   lw_state_t s_q;
   lw_state_t s_d;

   // Limit in half-ms ticks: 1.5 x time in ms equals 3 x half-ms
   logic [31:0] limit;
   assign limit = 32'(failure_time) * 32'(FAIL_MULT);

   // Next state
   always_comb begin
      s_d = s_q;
      if (failure_time == '0 || pd_received) begin   // see RL5
         s_d.pre    = '0;
         s_d.ticks  = '0;
         s_d.failed = 1'b0;
      end else begin
         // Prescale to half milliseconds
         if (s_q.pre == 32'(HALF_MS - 1)) begin
            s_d.pre = '0;
            if (s_q.ticks != 32'hFFFF_FFFF) begin
               s_d.ticks = s_q.ticks + 32'h0000_0001;
            end
         end else begin
            s_d.pre = s_q.pre + 32'h0000_0001;
         end
         // Failure once silence exceeds the limit
         if (s_q.ticks > limit) begin   // see RL3
            s_d.failed = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign failed = s_q.failed;

   // Disabled watch never flags
   property p_disabled_quiet;
      @(posedge clk_sys) disable iff (reset)
      (failure_time == '0) |=> !failed;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) // see RL5
      else $error("watch failed while disabled");

   // Receive clears failure next cycle
   property p_rx_clears;
      @(posedge clk_sys) disable iff (reset)
      pd_received |=> !failed;
   endproperty
   a_rx_clears: assert property (p_rx_clears) // see RL3
      else $error("failure not cleared by receive");

endmodule

// ==== rtl/signal_routing_and_link_watch.sv ====
// Connector fabric, summing selectors, group alarms and link watch
// Functional notes
// RL1: Tech alarm when any bit 0-10 set
// RL2: Interface alarm evaluated the same, separately
// RL3: Failure after 1.5x failure time silence
// RL4: Setting 4 alarms, setting 5 faults
// RL5: Zero failure time disables the watch
// RL6: Unused channels get zero failure time
// RL7: Transmit words carry selected connector values
// RL8: Selector value routes that numbered connector
// RL9: Connector zero is constant zero percent
// RL10: Connector one full scale, negative limits minus; the code always gives LVL_FULL
// RL11: Value two gives a selector-specific default
// RL12: Analog output one default is zero
// RL13: Four indices add at a summing point
// RL14: Ramp sum default main setpoint, then zero
// RL15: Limit sum default ramp output, then zero
// RL16: Base receive words on connectors 20-35
// RL17: Analog inputs on connectors five and six
// RL18: Evaluate once per firing-pulse cycle
// RL19: Group alarm follows contributing bits
`timescale 1ns/10ps
module signal_routing_and_link_watch
   import sig_route_pkg::*;
#(
   parameter int CYCLE     = CYCLE_CLKS,   // Clocks per firing-pulse cycle
   parameter int HALF_MS   = HALF_MS_CLKS  // Clocks per half millisecond
) (
   // Clock and reset
   input  wire logic                                 clk_sys,
   input  wire logic                                 reset,
   // Connector sources
   input  wire logic [DATA_W-1:0]                    main_setpoint_node,
   input  wire logic [DATA_W-1:0]                    analog_in1_node,
   input  wire logic [DATA_W-1:0]                    analog_in2_node,
   input  wire logic [DATA_W-1:0]                    ramp_output_node,
   input  wire logic [NUM_RX-1:0][DATA_W-1:0]        base_rx_words,
   input  wire logic [NUM_CONN-1:0][DATA_W-1:0]      other_nodes,
   // Selection values
   input  wire logic [CONN_W-1:0]                    analog_out1_selector,
   input  wire logic [NUM_IDX-1:0][CONN_W-1:0]       ramp_input_sum_selector,
   input  wire logic [NUM_IDX-1:0][CONN_W-1:0]       limit_input_selector,
   input  wire logic [NUM_TX-1:0][CONN_W-1:0]        tx_word_assign_ch1,
   input  wire logic [NUM_TX-1:0][CONN_W-1:0]        tx_word_assign_ch2,
   // Alarm words
   input  wire alarm_words_t                         tech_alarm_words,
   input  wire alarm_words_t                         iface_alarm_words,
   // Link watch
   input  wire logic                                 iface1_pd_received,
   input  wire logic                                 iface2_pd_received,
   input  wire logic [FAIL_TIME_W-1:0]               iface1_failure_time,
   input  wire logic [FAIL_TIME_W-1:0]               iface2_failure_time,
   input  wire logic [3:0]                           process_data_control_setting,
   // Routed outputs
   output logic [DATA_W-1:0]                         analog_out1_value,
   output logic [DATA_W-1:0]                         ramp_input_sum_node,
   output logic [DATA_W-1:0]                         limit_input_node,
   output logic [NUM_TX-1:0][DATA_W-1:0]             tx_words_ch1,
   output logic [NUM_TX-1:0][DATA_W-1:0]             tx_words_ch2,
   output logic                                      cycle_strobe,
   // Alarms
   output logic                                      tech_group_alarm,
   output logic                                      iface_group_alarm,
   output logic                                      link_loss_alarm,
   output logic                                      link_loss_fault
);

   // Whole state in one struct
   typedef struct packed {
      logic [31:0]                     cyc;
      logic                            strobe;
      logic [DATA_W-1:0]               ao1;
      logic [DATA_W-1:0]               ramp_sum;
      logic [DATA_W-1:0]               lim_sum;
      logic [NUM_TX-1:0][DATA_W-1:0]   tx1;
      logic [NUM_TX-1:0][DATA_W-1:0]   tx2;
      logic                            tech_al;
      logic                            iface_al;
      logic                            link_al;
      logic                            link_flt;
   } top_state_t;

   top_state_t s_q;
   top_state_t s_d;

   // Connector space, fixed nodes overlaid on general sources
   logic [NUM_CONN-1:0][DATA_W-1:0] conn;
   logic                            fail1;
   logic                            fail2;
   logic                            tech_any;
   logic                            iface_any;

   // Build the connector table
   always_comb begin
      conn = other_nodes;
      conn[CONN_ZERO]    = LVL_ZERO;           // see RL9
      conn[CONN_FULL]    = LVL_FULL;           // see RL10
      conn[CONN_DEFAULT] = LVL_ZERO;
      conn[CONN_MAIN_SP] = main_setpoint_node;
      conn[CONN_AIN1]    = analog_in1_node;    // see RL17
      conn[CONN_AIN2]    = analog_in2_node;    // see RL17
      conn[CONN_RAMP_OUT] = ramp_output_node;
      conn[CONN_RAMP_SUM] = s_q.ramp_sum;
      for (int i = 0; i < NUM_RX; i++) begin
         conn[int'(CONN_RX_FIRST) + i] = base_rx_words[i];   // see RL16
      end
   end

   // Pick one connector, with a per-selector default for value two
   function automatic logic [DATA_W-1:0] pick(
      input logic [NUM_CONN-1:0][DATA_W-1:0] c,
      input logic [CONN_W-1:0]               sel,
      input logic [DATA_W-1:0]               dflt
   );
      logic [DATA_W-1:0] v;
      v = c[sel];                    // see RL8
      if (sel == CONN_DEFAULT) begin
         v = dflt;                   // see RL11
      end
      return v;
   endfunction

   // Group alarm detection
   always_comb begin
      tech_any  = 1'b0;
      iface_any = 1'b0;
      for (int w = 0; w < NUM_ALARM_W; w++) begin
         tech_any  = tech_any  | (|tech_alarm_words.words[w][ALARM_BITS-1:0]);   // see RL1
         iface_any = iface_any | (|iface_alarm_words.words[w][ALARM_BITS-1:0]);  // see RL2
      end
   end

   // Next state: routing refreshed once per firing-pulse cycle
   always_comb begin
      logic [DATA_W-1:0] acc_r;
      logic [DATA_W-1:0] acc_l;
      logic              tick;
      acc_r = '0;
      acc_l = '0;
      tick  = (s_q.cyc == 32'(CYCLE - 1));
      s_d = s_q;
      s_d.strobe = tick;
      if (tick) begin   // see RL18
         s_d.cyc = '0;
         // Analog output one, default zero
         s_d.ao1 = pick(conn, analog_out1_selector, LVL_ZERO);   // see RL12
         // Summing selectors over four indices
         for (int k = 0; k < NUM_IDX; k++) begin
            acc_r = acc_r + pick(conn, ramp_input_sum_selector[k],
                                 (k == 0) ? main_setpoint_node : LVL_ZERO);   // see RL14
            acc_l = acc_l + pick(conn, limit_input_selector[k],
                                 (k == 0) ? ramp_output_node : LVL_ZERO);     // see RL15
         end
         s_d.ramp_sum = acc_r;   // see RL13
         s_d.lim_sum  = acc_l;   // see RL13
         // Transmit words, default value two gives zero
         for (int t = 0; t < NUM_TX; t++) begin
            s_d.tx1[t] = pick(conn, tx_word_assign_ch1[t], LVL_ZERO);   // see RL7
            s_d.tx2[t] = pick(conn, tx_word_assign_ch2[t], LVL_ZERO);   // see RL7
         end
      end else begin
         s_d.cyc = s_q.cyc + 32'h0000_0001;
      end
      // Alarms track inputs every clock
      s_d.tech_al  = tech_any;    // see RL19
      s_d.iface_al = iface_any;   // see RL19
      // Link failure classified by process data control setting
      s_d.link_al  = (fail1 | fail2) && process_data_control_setting == PDC_ALARM;   // see RL4
      s_d.link_flt = (fail1 | fail2) && process_data_control_setting == PDC_FAULT;   // see RL4
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Watches; unused channels rely on a zero failure time (see RL6)
   link_watch #(.HALF_MS(HALF_MS)) u_watch1 (
      .clk_sys      (clk_sys),
      .reset        (reset),
      .pd_received  (iface1_pd_received),
      .failure_time (iface1_failure_time),
      .failed       (fail1)
   );

   link_watch #(.HALF_MS(HALF_MS)) u_watch2 (
      .clk_sys      (clk_sys),
      .reset        (reset),
      .pd_received  (iface2_pd_received),
      .failure_time (iface2_failure_time),
      .failed       (fail2)
   );

   // Outputs from flops
   assign analog_out1_value   = s_q.ao1;
   assign ramp_input_sum_node = s_q.ramp_sum;
   assign limit_input_node    = s_q.lim_sum;
   assign tx_words_ch1        = s_q.tx1;
   assign tx_words_ch2        = s_q.tx2;
   assign cycle_strobe        = s_q.strobe;
   assign tech_group_alarm    = s_q.tech_al;
   assign iface_group_alarm   = s_q.iface_al;
   assign link_loss_alarm     = s_q.link_al;
   assign link_loss_fault     = s_q.link_flt;

   // Assertions
   property p_tech_alarm;
      @(posedge clk_sys) disable iff (reset)
      tech_any |=> tech_group_alarm;
   endproperty
   a_tech_alarm: assert property (p_tech_alarm) // see RL1
      else $error("tech group alarm missing");

   property p_iface_alarm;
      @(posedge clk_sys) disable iff (reset)
      iface_any |=> iface_group_alarm;
   endproperty
   a_iface_alarm: assert property (p_iface_alarm) // see RL2
      else $error("interface group alarm missing");

   property p_alarm_clear;
      @(posedge clk_sys) disable iff (reset)
      !tech_any && !iface_any |=> !tech_group_alarm && !iface_group_alarm;
   endproperty
   a_alarm_clear: assert property (p_alarm_clear) // see RL19
      else $error("group alarm stuck");

   property p_link_kind;
      @(posedge clk_sys) disable iff (reset)
      !(link_loss_alarm && link_loss_fault);
   endproperty
   a_link_kind: assert property (p_link_kind) // see RL4
      else $error("alarm and fault together");

   property p_fault_setting;
      @(posedge clk_sys) disable iff (reset)
      (fail1 && process_data_control_setting == PDC_FAULT) |=> link_loss_fault;
   endproperty
   a_fault_setting: assert property (p_fault_setting) // see RL4
      else $error("link fault not raised");

   // Second watch with alarm setting raises the link alarm
   property p_iface2_alarm;
      @(posedge clk_sys) disable iff (reset)
      (fail2 && process_data_control_setting == PDC_ALARM) |=> link_loss_alarm;
   endproperty
   a_iface2_alarm: assert property (p_iface2_alarm) // see RL4
      else $error("link alarm not raised");

   // No failure on either watch leaves both link outputs low
   property p_link_quiet;
      @(posedge clk_sys) disable iff (reset)
      (!fail1 && !fail2) |=> !link_loss_alarm && !link_loss_fault;
   endproperty
   a_link_quiet: assert property (p_link_quiet) // see RL3
      else $error("link output without failure");

   // Connector zero always reads zero percent
   property p_ao1_zero;
      @(posedge clk_sys) disable iff (reset)
      (s_q.cyc == 32'(CYCLE - 1) && analog_out1_selector == CONN_ZERO)
         |=> analog_out1_value == LVL_ZERO;
   endproperty
   a_ao1_zero: assert property (p_ao1_zero) // see RL9
      else $error("connector zero not zero");

   property p_strobe_spacing;
      @(posedge clk_sys) disable iff (reset)
      cycle_strobe |=> !cycle_strobe;
   endproperty
   a_strobe_spacing: assert property (p_strobe_spacing) // see RL18
      else $error("strobe too frequent");

   property p_ao1_stable;
      @(posedge clk_sys) disable iff (reset)
      !cycle_strobe |-> $stable(analog_out1_value);
   endproperty
   a_ao1_stable: assert property (p_ao1_stable) // see RL18
      else $error("output changed off cycle");

   property p_ao1_default;
      @(posedge clk_sys) disable iff (reset)
      (s_q.cyc == 32'(CYCLE - 1) && analog_out1_selector == CONN_DEFAULT)
         |=> analog_out1_value == LVL_ZERO;
   endproperty
   a_ao1_default: assert property (p_ao1_default) // see RL12
      else $error("default not zero");

   property p_ao1_full;
      @(posedge clk_sys) disable iff (reset)
      (s_q.cyc == 32'(CYCLE - 1) && analog_out1_selector == CONN_FULL)
         |=> analog_out1_value == LVL_FULL;
   endproperty
   a_ao1_full: assert property (p_ao1_full) // see RL10
      else $error("full scale wrong");

   // Main scenarios
   c_tech_alarm: cover property (@(posedge clk_sys) tech_group_alarm);
   c_link_alarm: cover property (@(posedge clk_sys) link_loss_alarm);
   c_link_fault: cover property (@(posedge clk_sys) link_loss_fault);
   c_refresh:    cover property (@(posedge clk_sys) cycle_strobe);
   c_ramp_dflt:  cover property (@(posedge clk_sys)
                    cycle_strobe && ramp_input_sum_selector[0] == CONN_DEFAULT);

endmodule

// ==== tb/link_master_model.sv ====
// Serial interface master model: sends process data telegrams at a set spacing
`timescale 1ns/10ps
module link_master_model (
   // Clock
   input  wire logic       clk_sys,
   // Control from the bench
   input  wire logic       active,
   input  wire logic [7:0] gap,
   // Link activity
   output logic            pd_received
);
   logic [7:0] cnt_q;   // Clocks since last telegram

   initial begin
      cnt_q = 8'h00;
      pd_received = 1'b0;
   end

   // One-clock pulse per telegram; silent when inactive, like a cut line
   always @(posedge clk_sys) begin
      if (active && cnt_q >= gap) begin
         cnt_q <= 8'h00;
         pd_received <= #1 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         pd_received <= #1 1'b0;
      end
   end
endmodule

// ==== tb/signal_routing_and_link_watch_tb.sv ====
// Self-checking bench for routing fabric, group alarms and link watch
`timescale 1ns/10ps
module signal_routing_and_link_watch_tb;
   import sig_route_pkg::*;
   localparam int CYC = 8;   // Short firing-pulse cycle
   localparam int HMS = 2;   // Short half millisecond
   localparam int NSL = 13;  // Size of selector table
   // Clock, reset and sources
   logic                                clk_sys;
   logic                                reset;
   logic [DATA_W-1:0]                   main_sp;
   logic [DATA_W-1:0]                   ain1;
   logic [DATA_W-1:0]                   ain2;
   logic [DATA_W-1:0]                   ramp_out;
   logic [NUM_RX-1:0][DATA_W-1:0]       rx;
   logic [NUM_CONN-1:0][DATA_W-1:0]     others;
   // Selectors
   logic [CONN_W-1:0]                   ao1_sel;
   logic [NUM_IDX-1:0][CONN_W-1:0]      ramp_sel;
   logic [NUM_IDX-1:0][CONN_W-1:0]      lim_sel;
   logic [NUM_TX-1:0][CONN_W-1:0]       tx1_sel;
   logic [NUM_TX-1:0][CONN_W-1:0]       tx2_sel;
   // Alarms and link
   alarm_words_t                        tech_w;
   alarm_words_t                        iface_w;
   logic                                pd1;
   logic                                pd2;
   logic                                act1;
   logic                                act2;
   logic [FAIL_TIME_W-1:0]              ft1;
   logic [FAIL_TIME_W-1:0]              ft2;
   logic [3:0]                          pdc;
   // Outputs
   logic [DATA_W-1:0]                   ao1;
   logic [DATA_W-1:0]                   rsum;
   logic [DATA_W-1:0]                   lsum;
   logic [NUM_TX-1:0][DATA_W-1:0]       tx1;
   logic [NUM_TX-1:0][DATA_W-1:0]       tx2;
   logic                                strobe;
   logic                                tga;
   logic                                iga;
   logic                                lla;
   logic                                llf;
   int                                  bad_count;
   int                                  compares;
   // Connectors worth probing, boundaries of each range included
   logic [CONN_W-1:0] sl [NSL] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h004, 9'h005, 9'h006,
                                   9'h014, 9'h015, 9'h023, 9'h024, 9'h0BE, 9'h1FF};

   signal_routing_and_link_watch #(.CYCLE(CYC), .HALF_MS(HMS)) uut (
      .clk_sys(clk_sys), .reset(reset), .main_setpoint_node(main_sp),
      .analog_in1_node(ain1), .analog_in2_node(ain2), .ramp_output_node(ramp_out),
      .base_rx_words(rx), .other_nodes(others), .analog_out1_selector(ao1_sel),
      .ramp_input_sum_selector(ramp_sel), .limit_input_selector(lim_sel),
      .tx_word_assign_ch1(tx1_sel), .tx_word_assign_ch2(tx2_sel),
      .tech_alarm_words(tech_w), .iface_alarm_words(iface_w),
      .iface1_pd_received(pd1), .iface2_pd_received(pd2),
      .iface1_failure_time(ft1), .iface2_failure_time(ft2),
      .process_data_control_setting(pdc), .analog_out1_value(ao1),
      .ramp_input_sum_node(rsum), .limit_input_node(lsum), .tx_words_ch1(tx1),
      .tx_words_ch2(tx2), .cycle_strobe(strobe), .tech_group_alarm(tga),
      .iface_group_alarm(iga), .link_loss_alarm(lla), .link_loss_fault(llf));

   // Far-side masters, one telegram every four clocks while active
   link_master_model m1 (.clk_sys(clk_sys), .active(act1), .gap(8'h03), .pd_received(pd1));
   link_master_model m2 (.clk_sys(clk_sys), .active(act2), .gap(8'h03), .pd_received(pd2));

   // 50 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Verdict and end of run
   task automatic final_report;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Compare one value, four-state exact
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                      input string what);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Wait for the next cycle strobe, bounded; n gives clocks waited after the first
   task automatic wait_strobe(output int n);
      n = 0;
      @(posedge clk_sys);
      #1;
      while (strobe !== 1'b1 && n < 40) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 40) begin
         bad_count++;
         $display("mismatch at %0t: no cycle strobe", $time);
         final_report;
      end
   endtask

   // Expected connector value; dflt is what value two means here
   function automatic logic [DATA_W-1:0] node(input logic [CONN_W-1:0] k,
                                              input logic [DATA_W-1:0] dflt);
      if (k == CONN_ZERO) return LVL_ZERO;
      if (k == CONN_FULL) return LVL_FULL;
      if (k == CONN_DEFAULT) return dflt;
      if (k == CONN_MAIN_SP) return main_sp;
      if (k == CONN_AIN1) return ain1;
      if (k == CONN_AIN2) return ain2;
      if (k >= CONN_RX_FIRST && k <= CONN_RX_LAST) return rx[k - CONN_RX_FIRST];
      if (k == CONN_RAMP_OUT) return ramp_out;
      return others[k];
   endfunction

   // One link case: warm up with traffic, then cut links and time the reaction
   task automatic link_case(input logic [3:0] set, input logic [FAIL_TIME_W-1:0] t1,
                            input logic [FAIL_TIME_W-1:0] t2, input logic a1,
                            input logic a2, input logic ea, input logic ef);
      int n;
      pdc = set;
      ft1 = t1;
      ft2 = t2;
      act1 = 1'b1;
      act2 = 1'b1;
      repeat (20) @(posedge clk_sys);
      #1;
      act1 = a1;
      act2 = a2;
      n = 0;
      while (!(lla === 1'b1 || llf === 1'b1) && n < 60) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      // Limit for time 4 ms is 24 clocks here; allow tick phase and two clocks of latency
      compares++;
      if ((ea || ef) ? (n < 18 || n > 40) : (n != 60)) begin
         bad_count++;
         $display("mismatch at %0t: link reaction after %0d clocks", $time, n);
      end
      chk({14'h0000, lla, llf}, {14'h0000, ea, ef}, "link alarm and fault");
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      $display("mismatch at %0t: run timed out", $time);
      final_report;
   end

   // Main sequence
   initial begin
      logic [DATA_W-1:0] er;
      logic [DATA_W-1:0] el;
      int n;
      bad_count = 0;
      compares = 0;
      reset = 1'b1;
      main_sp = 16'h1234;
      ain1 = 16'h0567;
      ain2 = 16'hF0F0;
      ramp_out = 16'h2222;
      for (int i = 0; i < NUM_CONN; i++) others[i] = 16'(i * 37) ^ 16'h5A5A;
      for (int i = 0; i < NUM_RX; i++) rx[i] = 16'h0100 + 16'(i * 3);
      for (int i = 0; i < NUM_TX; i++) begin
         tx1_sel[i] = 9'(i * 31);
         tx2_sel[i] = CONN_RX_FIRST + 9'(i);
      end
      tx1_sel[1] = CONN_DEFAULT;
      ao1_sel = CONN_DEFAULT;
      ramp_sel = '0;
      lim_sel = '0;
      tech_w = '0;
      iface_w = '0;
      act1 = 1'b1;
      act2 = 1'b1;
      ft1 = 16'h0000;
      ft2 = 16'h0000;
      pdc = 4'h0;
      repeat (8) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      chk({ao1[15:2], tga, lla}, 16'h0000, "outputs after reset");
      // Sweep the selector table over analog out one and both summing selectors
      for (int k = 0; k < NSL; k++) begin
         ao1_sel = sl[k];
         for (int j = 0; j < NUM_IDX; j++) begin
            ramp_sel[j] = sl[(k + j) % NSL];
            lim_sel[j] = sl[(k + 3 * j) % NSL];
         end
         wait_strobe(n);
         wait_strobe(n);
         chk(16'(n), 16'(CYC - 1), "strobe spacing");
         er = node(ramp_sel[0], main_sp);
         el = node(lim_sel[0], ramp_out);
         for (int j = 1; j < NUM_IDX; j++) begin
            er += node(ramp_sel[j], LVL_ZERO);
            el += node(lim_sel[j], LVL_ZERO);
         end
         chk(ao1, node(sl[k], LVL_ZERO), "analog out one");
         chk(rsum, er, "ramp input sum");
         chk(lsum, el, "limit input sum");
      end
      // Transmit words on both channels
      for (int i = 0; i < NUM_TX; i++) begin
         chk(tx1[i], node(tx1_sel[i], LVL_ZERO), "tx word ch1");
         chk(tx2[i], node(tx2_sel[i], LVL_ZERO), "tx word ch2");
      end
      // Walk one bit through every alarm word, both channels
      for (int s = 0; s < 2; s++) begin
         for (int w = 0; w < NUM_ALARM_W; w++) begin
            for (int b = 0; b < DATA_W; b++) begin
               tech_w = '0;
               iface_w = '0;
               if (s == 0) tech_w.words[w][b] = 1'b1;
               else iface_w.words[w][b] = 1'b1;
               repeat (3) @(posedge clk_sys);
               #1;
               chk({15'h0000, tga}, {15'h0000, s == 0 && b < ALARM_BITS}, "tech alarm");
               chk({15'h0000, iga}, {15'h0000, s == 1 && b < ALARM_BITS}, "iface alarm");
            end
         end
      end
      tech_w = '0;
      iface_w = '0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk({14'h0000, tga, iga}, 16'h0000, "alarms cleared");
      // Link watch: unused channel time held at zero by the configuring side
      link_case(PDC_ALARM, 16'h0004, 16'h0000, 1'b0, 1'b0, 1'b1, 1'b0);
      link_case(PDC_FAULT, 16'h0004, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1);
      link_case(PDC_ALARM, 16'h0000, 16'h0004, 1'b0, 1'b0, 1'b1, 1'b0);
      link_case(PDC_ALARM, 16'h0004, 16'h0004, 1'b1, 1'b1, 1'b0, 1'b0);
      link_case(PDC_FAULT, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0);
      link_case(4'h3, 16'h0004, 16'h0004, 1'b0, 1'b0, 1'b0, 1'b0);
      final_report;
   end
endmodule
